// [rtl/fscr_regs.sv]
// Status and configuration register bank of a serial NOR flash with its serial front end.
`timescale 1ns/10ps

module fscr_regs
	import fscr_pkg::*;
#(
	parameter int TW_CYCLES = T_WRITE_CYCLES,
	parameter logic [15:0] STATUS_INIT = ST_RESET,
	parameter logic [7:0] CONFIG_INIT = CF_RESET
) (
	// Clock and power-on reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Serial pins from the host controller.
	input wire logic cs_n_i,
	input wire logic sclk_i,
	input wire logic si_i,
	input wire logic wp_n_i,
	input wire logic hold_n_i,
	output logic so_o,
	output logic so_oe_o,
	// Pin function and read timing settings.
	output logic quad_io_en_o,
	output logic hold_func_en_o,
	output logic reset_func_en_o,
	output logic [1:0] drive_strength_o,
	output logic [3:0] dummy_sdr_2io_o,
	output logic [3:0] dummy_sdr_4io_o,
	output logic [3:0] dummy_ddr_1io_o,
	output logic [3:0] dummy_ddr_4io_o,
	// Protection and address settings.
	output logic [4:0] block_protect_o,
	output logic protect_cmp_o,
	output logic [2:0] secure_lock_o,
	output logic protect_scheme_o,
	output logic block_locks_preset_o,
	output logic addr_4byte_o,
	output logic busy_o,
	// Array engine handshake (same clock).
	output logic arr_go_o,
	output logic [7:0] arr_cmd_o,
	output logic arr_abort_o,
	output logic suspend_o,
	input wire logic arr_protected_i,
	input wire logic arr_done_i,
	input wire logic arr_fail_i
);

	initial begin
		if (TW_CYCLES < 1 || TW_CYCLES > 65535) begin
			$error("TW_CYCLES out of range");
		end
	end

	// Dummy clock count for one read family and wait select.
	function automatic logic [3:0] dummy_count(input logic [1:0] fam, input logic [1:0] dc);
		logic [3:0] n;
		n = 4'h8;
		unique case (fam)
			2'd0: n = (dc == 2'b00) ? 4'h4 : 4'h8;
			2'd1: begin
				unique case (dc)
					2'b00: n = 4'h6;
					2'b01: n = 4'hc;
					2'b10: n = 4'h8;
					2'b11: n = 4'ha;
				endcase
			end
			2'd2: n = (dc == 2'b00) ? 4'h6 : 4'h8;
			2'd3: begin
				unique case (dc)
					2'b00: n = 4'ha;
					2'b01: n = 4'h8;
					2'b10: n = 4'h6;
					2'b11: n = 4'hc;
				endcase
			end
		endcase
		return n;
	endfunction

	// ==========================================================================
	// Pin synchronisers
	// ==========================================================================
	// Bit order: 0 chip select, 1 clock, 2 data in, 3 protect, 4 pause.
	logic [4:0] pin_raw;
	logic [4:0] sync1_reg, sync2_reg, sync3_reg, filt_reg, filt_d_reg;
	logic [4:0] filt_next;

	assign pin_raw = {hold_n_i, wp_n_i, si_i, sclk_i, cs_n_i};

	// A level is accepted once the second and third stages agree.
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			filt_next[i] = (sync2_reg[i] == sync3_reg[i]) ? sync3_reg[i] : filt_reg[i];
		end
	end

	// Synchroniser stages; active-low pins idle high, the serial clock idles low.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			sync1_reg <= 5'h19;
			sync2_reg <= 5'h19;
			sync3_reg <= 5'h19;
			filt_reg <= 5'h19;
			filt_d_reg <= 5'h19;
		end else begin
			sync1_reg <= pin_raw;
			sync2_reg <= sync1_reg;
			sync3_reg <= sync2_reg;
			filt_reg <= filt_next;
			filt_d_reg <= filt_reg;
		end
	end

	// ==========================================================================
	// Serial front end and register bank
	// ==========================================================================
	fscr_ser_t st_reg, st_next;
	logic [5:0] bitcnt_reg, bitcnt_next;
	logic [7:0] sh_in_reg, sh_in_next;
	logic [7:0] op_reg, op_next;
	logic [7:0] d0_reg, d0_next;
	logic [7:0] d1_reg, d1_next;
	logic [7:0] sh_out_reg, sh_out_next;
	logic so_reg, so_next;
	logic rd_on_reg, rd_on_next;
	logic [15:0] status_reg, status_next;
	logic [7:0] config_reg, config_next;
	logic [15:0] tw_cnt_reg, tw_cnt_next;
	logic wbusy_reg, wbusy_next;
	logic arr_active_reg, arr_active_next;
	logic armed_reg, armed_next;
	logic go_reg, go_next;
	logic [7:0] cmd_reg, cmd_next;
	logic abort_reg, abort_next;
	logic preset_reg, preset_next;

	logic selected, cs_rise, sclk_rise, sclk_fall, hold_active, pin_reset;
	logic qe, busy, sr_write_ok, is_array_op, is_full_clear, soft_reset, dev_reset;
	logic [15:0] status_view;
	logic [7:0] rd_byte;
	logic [7:0] in_byte;
	logic [15:0] sr_new;

	assign selected = ~filt_reg[0];
	assign cs_rise = filt_reg[0] & ~filt_d_reg[0];
	assign qe = status_reg[ST_QE];
	// Pause and reset only exist while quad mode is off.
	assign hold_active = ~qe & ~config_reg[CF_HOLD_RST] & ~filt_reg[4];
	assign pin_reset = ~qe & config_reg[CF_HOLD_RST] & ~filt_reg[4];
	assign sclk_rise = selected & ~hold_active & filt_reg[1] & ~filt_d_reg[1];
	assign sclk_fall = selected & ~hold_active & ~filt_reg[1] & filt_d_reg[1];
	// A suspended array operation does not show as busy.
	assign busy = wbusy_reg | (arr_active_reg & ~status_reg[ST_SUS]);
	assign in_byte = {sh_in_reg[6:0], filt_reg[2]};

	// Status as read back, with the live busy flag in bit 0.
	assign status_view = {status_reg[15:1], busy};

	// Hardware lock decode: 00 always, 01 only with protect pin high.
	always_comb begin
		unique case ({status_reg[ST_LOCK1], status_reg[ST_LOCK0]})
			2'b00: sr_write_ok = status_reg[ST_WEL];
			2'b01: sr_write_ok = status_reg[ST_WEL] & filt_reg[3];
			2'b10: sr_write_ok = 1'b0;
			2'b11: sr_write_ok = 1'b0;
		endcase
	end

	assign is_full_clear = (op_reg == OP_FULL_CLEAR_A) || (op_reg == OP_FULL_CLEAR_B);
	assign is_array_op = is_full_clear || (op_reg == OP_PAGE_WRITE) ||
		(op_reg == OP_PAGE_CLEAR) || (op_reg == OP_BLOCK4K_CLEAR) ||
		(op_reg == OP_BLOCK64K_CLEAR);
	assign soft_reset = cs_rise && armed_reg && op_reg == OP_RESET_GO && bitcnt_reg == 6'd8;
	assign dev_reset = soft_reset | pin_reset;

	// Byte selected for the read currently in progress.
	always_comb begin
		if (op_reg == OP_RD_STATUS_LO) begin
			rd_byte = status_view[7:0];
		end else if (op_reg == OP_RD_STATUS_HI) begin
			rd_byte = status_view[15:8];
		end else begin
			rd_byte = config_reg;
		end
	end

	// New status word: only writable bits move, locks only ever set.
	always_comb begin
		sr_new = (status_reg & ~ST_WRITE_MASK) | ({d1_reg, d0_reg} & ST_WRITE_MASK);
		if (bitcnt_reg == 6'd16) begin
			sr_new[15:8] = status_reg[15:8];
		end
		sr_new[ST_LB_LSB +: 3] = status_reg[ST_LB_LSB +: 3] | sr_new[ST_LB_LSB +: 3];
	end

	// Next state of the serial front end and the register bank.
	always_comb begin
		st_next = st_reg;
		bitcnt_next = bitcnt_reg;
		sh_in_next = sh_in_reg;
		op_next = op_reg;
		d0_next = d0_reg;
		d1_next = d1_reg;
		sh_out_next = sh_out_reg;
		so_next = so_reg;
		rd_on_next = rd_on_reg & ~hold_active;
		status_next = status_reg;
		config_next = config_reg;
		tw_cnt_next = tw_cnt_reg;
		wbusy_next = wbusy_reg;
		arr_active_next = arr_active_reg;
		armed_next = armed_reg;
		go_next = 1'b0;
		cmd_next = cmd_reg;
		abort_next = 1'b0;
		preset_next = 1'b0;

		// Self-timed register write cycle.
		if (wbusy_reg) begin
			if (tw_cnt_reg == 16'h0000) begin
				wbusy_next = 1'b0;
				status_next[ST_WEL] = 1'b0;
			end else begin
				tw_cnt_next = tw_cnt_reg - 16'h0001;
			end
		end

		// Array engine completion; a status write accepted in the same cycle overrides these bits.
		if (arr_active_reg && arr_done_i) begin
			arr_active_next = 1'b0;
			status_next[ST_FAIL] = arr_fail_i;
			status_next[ST_WEL] = 1'b0;
			status_next[ST_SUS] = 1'b0;
		end

		// Serial bit capture on the rising clock edge.
		unique case (st_reg)
			SER_IDLE: begin
				if (selected) begin
					st_next = SER_CMD;
					bitcnt_next = 6'd0;
				end
			end
			SER_CMD, SER_WDATA, SER_READ, SER_SKIP: begin
				if (sclk_rise) begin
					sh_in_next = in_byte;
					if (bitcnt_reg != 6'h3f) begin
						bitcnt_next = bitcnt_reg + 6'd1;
					end
					if (st_reg == SER_CMD && bitcnt_reg == 6'd7) begin
						op_next = in_byte;
						if (in_byte == OP_RD_STATUS_LO || in_byte == OP_RD_STATUS_HI ||
							in_byte == OP_RD_CONFIG) begin
							st_next = SER_READ;
						end else if (in_byte == OP_WR_STATUS || in_byte == OP_WR_CONFIG) begin
							st_next = SER_WDATA;
						end else begin
							st_next = SER_SKIP;
						end
					end
					if (st_reg == SER_WDATA && bitcnt_reg == 6'd15) begin
						d0_next = in_byte;
					end
					if (st_reg == SER_WDATA && bitcnt_reg == 6'd23) begin
						d1_next = in_byte;
					end
				end
				// Read data leaves MSB first on the falling edge, byte repeating for seven bytes, then zeros once the bit count stops at 63.
				if (st_reg == SER_READ && sclk_fall && bitcnt_reg >= 6'd8) begin
					rd_on_next = 1'b1;
					if (bitcnt_reg[2:0] == 3'd0) begin
						so_next = rd_byte[7];
						sh_out_next = {rd_byte[6:0], 1'b0};
					end else begin
						so_next = sh_out_reg[7];
						sh_out_next = {sh_out_reg[6:0], 1'b0};
					end
				end
			end
			default: st_next = SER_IDLE;
		endcase

		// Command execution when chip select rises.
		if (cs_rise) begin
			st_next = SER_IDLE;
			rd_on_next = 1'b0;
			armed_next = (op_reg == OP_RESET_ARM) && bitcnt_reg == 6'd8;
			if (!busy && bitcnt_reg == 6'd8 && op_reg == OP_WR_ENABLE) begin
				status_next[ST_WEL] = 1'b1;
			end
			if (!busy && bitcnt_reg == 6'd8 && op_reg == OP_WR_DISABLE) begin
				status_next[ST_WEL] = 1'b0;
			end
			// Block protect and lock bits change only outside hardware lock.
			if (!busy && op_reg == OP_WR_STATUS && (bitcnt_reg == 6'd16 || bitcnt_reg == 6'd24)
				&& sr_write_ok) begin
				status_next = sr_new;
				status_next[ST_WEL] = 1'b1;
				wbusy_next = 1'b1;
				tw_cnt_next = 16'(TW_CYCLES - 1);
			end
			if (!busy && op_reg == OP_WR_CONFIG && bitcnt_reg == 6'd16 && status_reg[ST_WEL]) begin
				config_next = (config_reg & ~CF_WRITE_MASK) | (d0_reg & CF_WRITE_MASK);
				wbusy_next = 1'b1;
				tw_cnt_next = 16'(TW_CYCLES - 1);
			end
			if (!busy && is_array_op && bitcnt_reg >= 6'd8 && bitcnt_reg[2:0] == 3'd0 &&
				status_reg[ST_WEL]) begin
				if (is_full_clear && status_reg[ST_BP_LSB +: 5] != 5'h00) begin
					status_next[ST_FAIL] = 1'b1;
					status_next[ST_WEL] = 1'b0;
				end else if (!is_full_clear && arr_protected_i) begin
					status_next[ST_FAIL] = 1'b1;
					status_next[ST_WEL] = 1'b0;
				end else begin
					arr_active_next = 1'b1;
					go_next = 1'b1;
					cmd_next = op_reg;
				end
			end
			if (op_reg == OP_SUSPEND && bitcnt_reg == 6'd8 && arr_active_reg) begin
				status_next[ST_SUS] = 1'b1;
			end
			if (op_reg == OP_RESUME && bitcnt_reg == 6'd8) begin
				status_next[ST_SUS] = 1'b0;
			end
			if (!busy && op_reg == OP_ENTER_4B && bitcnt_reg == 6'd8) begin
				config_next[CF_ADS] = 1'b1;
			end
			if (!busy && op_reg == OP_EXIT_4B && bitcnt_reg == 6'd8) begin
				config_next[CF_ADS] = 1'b0;
			end
		end

		// Soft or pin reset: nonvolatile bits stay, volatile state restarts.
		if (dev_reset) begin
			st_next = SER_IDLE;
			rd_on_next = 1'b0;
			armed_next = 1'b0;
			wbusy_next = 1'b0;
			status_next[ST_WEL] = 1'b0;
			status_next[ST_SUS] = 1'b0;
			config_next[CF_ADS] = config_reg[CF_ADP];
			preset_next = 1'b1;
			go_next = 1'b0;
			if (arr_active_reg) begin
				arr_active_next = 1'b0;
				abort_next = 1'b1;
				status_next[ST_FAIL] = 1'b1;
			end
		end
	end

	// Registers of the front end and the bank; power-on reloads stored values.
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			st_reg <= SER_IDLE;
			bitcnt_reg <= 6'd0;
			sh_in_reg <= 8'h00;
			op_reg <= 8'h00;
			d0_reg <= 8'h00;
			d1_reg <= 8'h00;
			sh_out_reg <= 8'h00;
			so_reg <= 1'b0;
			rd_on_reg <= 1'b0;
			status_reg <= STATUS_INIT & 16'h7e7c;
			config_reg <= {CONFIG_INIT[7:1], CONFIG_INIT[CF_ADP]};
			tw_cnt_reg <= 16'h0000;
			wbusy_reg <= 1'b0;
			arr_active_reg <= 1'b0;
			armed_reg <= 1'b0;
			go_reg <= 1'b0;
			cmd_reg <= 8'h00;
			abort_reg <= 1'b0;
			preset_reg <= 1'b1;
		end else begin
			st_reg <= st_next;
			bitcnt_reg <= bitcnt_next;
			sh_in_reg <= sh_in_next;
			op_reg <= op_next;
			d0_reg <= d0_next;
			d1_reg <= d1_next;
			sh_out_reg <= sh_out_next;
			so_reg <= so_next;
			rd_on_reg <= rd_on_next;
			status_reg <= status_next;
			config_reg <= config_next;
			tw_cnt_reg <= tw_cnt_next;
			wbusy_reg <= wbusy_next;
			arr_active_reg <= arr_active_next;
			armed_reg <= armed_next;
			go_reg <= go_next;
			cmd_reg <= cmd_next;
			abort_reg <= abort_next;
			preset_reg <= preset_next;
		end
	end

	// ==========================================================================
	// Registered outputs
	// ==========================================================================
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			so_o <= 1'b0;
			so_oe_o <= 1'b0;
			quad_io_en_o <= 1'b0;
			hold_func_en_o <= 1'b0;
			reset_func_en_o <= 1'b0;
			drive_strength_o <= 2'b00;
			dummy_sdr_2io_o <= 4'h4;
			dummy_sdr_4io_o <= 4'h6;
			dummy_ddr_1io_o <= 4'h6;
			dummy_ddr_4io_o <= 4'ha;
			block_protect_o <= 5'h00;
			protect_cmp_o <= 1'b0;
			secure_lock_o <= 3'h0;
			protect_scheme_o <= 1'b0;
			block_locks_preset_o <= 1'b0;
			addr_4byte_o <= 1'b0;
			busy_o <= 1'b0;
			arr_go_o <= 1'b0;
			arr_cmd_o <= 8'h00;
			arr_abort_o <= 1'b0;
			suspend_o <= 1'b0;
		end else begin
			so_o <= so_reg;
			so_oe_o <= rd_on_reg & selected & ~hold_active;
			quad_io_en_o <= qe;
			hold_func_en_o <= ~qe & ~config_reg[CF_HOLD_RST];
			reset_func_en_o <= ~qe & config_reg[CF_HOLD_RST];
			drive_strength_o <= config_reg[CF_DRV_LSB +: 2];
			dummy_sdr_2io_o <= dummy_count(2'd0, config_reg[CF_DC_LSB +: 2]);
			dummy_sdr_4io_o <= dummy_count(2'd1, config_reg[CF_DC_LSB +: 2]);
			dummy_ddr_1io_o <= dummy_count(2'd2, config_reg[CF_DC_LSB +: 2]);
			dummy_ddr_4io_o <= dummy_count(2'd3, config_reg[CF_DC_LSB +: 2]);
			block_protect_o <= status_reg[ST_BP_LSB +: 5];
			protect_cmp_o <= status_reg[ST_CMP];
			secure_lock_o <= status_reg[ST_LB_LSB +: 3];
			protect_scheme_o <= config_reg[CF_WPS];
			block_locks_preset_o <= preset_reg;
			addr_4byte_o <= config_reg[CF_ADS];
			busy_o <= busy;
			arr_go_o <= go_reg;
			arr_cmd_o <= cmd_reg;
			arr_abort_o <= abort_reg;
			suspend_o <= status_reg[ST_SUS];
		end
	end

endmodule

// [rtl/fscr_pkg.sv]
// Constants shared by the flash status and configuration register bank.
package fscr_pkg;

	// ==========================================================================
	// Command opcodes
	// ==========================================================================
	localparam logic [7:0] OP_WR_ENABLE = 8'h06;
	localparam logic [7:0] OP_WR_DISABLE = 8'h04;
	localparam logic [7:0] OP_RD_STATUS_LO = 8'h05;
	localparam logic [7:0] OP_RD_STATUS_HI = 8'h35;
	localparam logic [7:0] OP_RD_CONFIG = 8'h15;
	localparam logic [7:0] OP_WR_STATUS = 8'h01;
	localparam logic [7:0] OP_WR_CONFIG = 8'h11;
	localparam logic [7:0] OP_PAGE_WRITE = 8'h02;
	localparam logic [7:0] OP_PAGE_CLEAR = 8'h81;
	localparam logic [7:0] OP_BLOCK4K_CLEAR = 8'h20;
	localparam logic [7:0] OP_BLOCK64K_CLEAR = 8'hd8;
	localparam logic [7:0] OP_FULL_CLEAR_A = 8'hc7;
	localparam logic [7:0] OP_FULL_CLEAR_B = 8'h60;
	localparam logic [7:0] OP_SUSPEND = 8'h75;
	localparam logic [7:0] OP_RESUME = 8'h7a;
	localparam logic [7:0] OP_ENTER_4B = 8'hb7;
	localparam logic [7:0] OP_EXIT_4B = 8'he9;
	localparam logic [7:0] OP_RESET_ARM = 8'h66;
	localparam logic [7:0] OP_RESET_GO = 8'h99;

	// ==========================================================================
	// Status word field positions
	// ==========================================================================
	localparam int ST_WIP = 0;
	localparam int ST_WEL = 1;
	localparam int ST_BP_LSB = 2;
	localparam int ST_LOCK0 = 7;
	localparam int ST_LOCK1 = 8;
	localparam int ST_QE = 9;
	localparam int ST_FAIL = 10;
	localparam int ST_LB_LSB = 11;
	localparam int ST_CMP = 14;
	localparam int ST_SUS = 15;
	// Bits that the status write may change (all but 15, 10, 1 and 0).
	localparam logic [15:0] ST_WRITE_MASK = 16'h7bfc;
	// Power-on contents of the status word.
	localparam logic [15:0] ST_RESET = 16'h0000;

	// ==========================================================================
	// Configuration byte field positions
	// ==========================================================================
	localparam int CF_ADS = 0;
	localparam int CF_ADP = 1;
	localparam int CF_WPS = 2;
	localparam int CF_DC_LSB = 3;
	localparam int CF_DRV_LSB = 5;
	localparam int CF_HOLD_RST = 7;
	// Bit 0 reports the live address mode and ignores writes.
	localparam logic [7:0] CF_WRITE_MASK = 8'hfe;
	localparam logic [7:0] CF_RESET = 8'h00;

	// ==========================================================================
	// Timing
	// ==========================================================================
	localparam int CLK_PERIOD_NS = 40;
	// Self-timed register write cycle; the figure is a plain default.
	localparam int T_WRITE_NS = 5000;
	localparam int T_WRITE_CYCLES = (T_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// Serial front end states.
	typedef enum logic [4:0] {
		SER_IDLE = 5'b00001,
		SER_CMD = 5'b00010,
		SER_READ = 5'b00100,
		SER_WDATA = 5'b01000,
		SER_SKIP = 5'b10000
	} fscr_ser_t;

endpackage

// [test/fscr_regs_assertions.sv]
// Concurrent checks on the ports of the register bank.
`timescale 1ns/10ps
module fscr_regs_assertions (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Watched pins and settings.
	input wire logic cs_n_i,
	input wire logic so_oe_o,
	input wire logic quad_io_en_o,
	input wire logic hold_func_en_o,
	input wire logic reset_func_en_o,
	input wire logic [1:0] drive_strength_o,
	input wire logic [3:0] dummy_sdr_2io_o,
	input wire logic [3:0] dummy_sdr_4io_o,
	input wire logic [3:0] dummy_ddr_1io_o,
	input wire logic [3:0] dummy_ddr_4io_o,
	input wire logic [4:0] block_protect_o,
	input wire logic block_locks_preset_o,
	input wire logic busy_o,
	input wire logic arr_go_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	// ==========================================================================
	// Steps of a frame and of a settings update.
	// ==========================================================================
	sequence s_frame_end;
		$rose(cs_n_i);
	endsequence
	sequence s_read_start;
		$rose(so_oe_o);
	endsequence
	sequence s_setting_move;
		$changed(block_protect_o) || $changed(drive_strength_o);
	endsequence
	// ==========================================================================
	// Assertions.
	// ==========================================================================
	oe_start_a: assert property (s_read_start |-> !cs_n_i)
		else $error("output enabled outside a frame");
	oe_stop_a: assert property (s_frame_end |-> ##[1:8] !so_oe_o)
		else $error("output still enabled after the frame");
	go_busy_a: assert property (arr_go_o |-> ##[0:2] busy_o)
		else $error("array start without busy");
	write_busy_a: assert property (s_setting_move |-> ##[0:2] busy_o)
		else $error("setting changed without a write cycle");
	preset_pulse_a: assert property ($rose(rst_n_i) |-> ##[0:2] block_locks_preset_o)
		else $error("no lock preset after reset");
	quad_pin_a: assert property (quad_io_en_o |-> !hold_func_en_o && !reset_func_en_o)
		else $error("pause or reset active in quad mode");
	pin_func_a: assert property ($past(rst_n_i, 2) && !quad_io_en_o |->
		hold_func_en_o ^ reset_func_en_o)
		else $error("pin function not exactly one of pause and reset");
	dummy_pair_a: assert property ((dummy_sdr_2io_o == 4'h4) == (dummy_ddr_1io_o == 4'h6) &&
		(dummy_sdr_4io_o == 4'h6) == (dummy_ddr_4io_o == 4'ha) &&
		(dummy_sdr_4io_o == 4'hc) == (dummy_ddr_4io_o == 4'h8))
		else $error("dummy counts disagree");
endmodule

bind fscr_regs fscr_regs_assertions chk (.clk_i, .rst_n_i, .cs_n_i, .so_oe_o, .quad_io_en_o,
	.hold_func_en_o, .reset_func_en_o, .drive_strength_o, .dummy_sdr_2io_o, .dummy_sdr_4io_o,
	.dummy_ddr_1io_o, .dummy_ddr_4io_o, .block_protect_o, .block_locks_preset_o, .busy_o,
	.arr_go_o);

// [test/fscr_host_model.sv]
// Serial host controller model that frames commands on the flash pins.
`timescale 1ns/10ps
module fscr_host_model (
	// Bench clock that paces the serial clock.
	input wire logic clk_i,
	// Serial pins toward the flash.
	output logic cs_n_o,
	output logic sclk_o,
	output logic si_o,
	input wire logic so_i
);
	logic [7:0] rx_last;
	event got;
	// Idle: deselected, serial clock parked low.
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		si_o = 1'b0;
	end
	// Waits n falling edges of the bench clock.
	task automatic half(input int n);
		repeat (n) @(negedge clk_i);
	endtask
	// Sends nb bits msb first, then clocks in nrx bytes; slow stretches each phase.
	task automatic xfer(input logic [31:0] tx, input int nb, input int nrx, input int slow);
		half(2);
		cs_n_o = 1'b0;
		for (int i = nb - 1; i >= 0; i--) begin
			si_o = tx[i];
			half(4 + slow);
			sclk_o = 1'b1;
			half(4 + slow);
			sclk_o = 1'b0;
		end
		for (int b = 0; b < nrx; b++) begin
			for (int i = 7; i >= 0; i--) begin
				si_o = ~si_o;
				half(4 + slow);
				sclk_o = 1'b1;
				half(3 + slow);
				rx_last[i] = so_i;
				half(1);
				sclk_o = 1'b0;
			end
			-> got;
		end
		half(4);
		cs_n_o = 1'b1;
		si_o = ~si_o;
		half(8);
	endtask
endmodule

// [test/fscr_regs_bench.sv]
// Self-checking bench for the flash status and configuration register bank.
`timescale 1ns/10ps
`define CHK(e, g) begin comparisons++; if ((g) !== (e)) begin n_fail++; \
	$display("CHECK FAILED at %0t exp %h got %h", $time, e, g); end end
module fscr_regs_bench
	import fscr_pkg::*;
();
	logic clk_i = 1'b0, rst_n_i = 1'b0, cs_n_i, sclk_i, si_i, wp_n_i = 1'b1, hold_n_i = 1'b1;
	logic arr_protected_i = 1'b0, arr_done_i = 1'b0, arr_fail_i = 1'b0;
	logic so_o, so_oe_o, quad_io_en_o, hold_func_en_o, reset_func_en_o, protect_cmp_o;
	logic block_locks_preset_o, addr_4byte_o, busy_o, arr_go_o, suspend_o;
	logic [1:0] drive_strength_o;
	logic [3:0] dummy_sdr_2io_o, dummy_sdr_4io_o, dummy_ddr_1io_o, dummy_ddr_4io_o;
	logic [4:0] block_protect_o;
	logic [2:0] secure_lock_o;
	logic [7:0] seed = 8'h30, vlo, vhi, cfg, exp_b, q[$];
	logic [3:0] t4[4] = '{4'h6, 4'hc, 4'h8, 4'ha};
	logic [3:0] u4[4] = '{4'ha, 4'h8, 4'h6, 4'hc};
	int n_fail = 0, comparisons = 0, cycles = 0, n_go = 0, n_pre = 0, p0;
	// Device under test with a short write cycle.
	fscr_regs #(.TW_CYCLES(40)) dut (.clk_i, .rst_n_i, .cs_n_i, .sclk_i, .si_i, .wp_n_i,
		.hold_n_i, .so_o, .so_oe_o, .quad_io_en_o, .hold_func_en_o, .reset_func_en_o,
		.drive_strength_o, .dummy_sdr_2io_o, .dummy_sdr_4io_o, .dummy_ddr_1io_o,
		.dummy_ddr_4io_o, .block_protect_o, .protect_cmp_o, .secure_lock_o,
		.protect_scheme_o(), .block_locks_preset_o, .addr_4byte_o, .busy_o, .arr_go_o,
		.arr_cmd_o(), .arr_abort_o(), .suspend_o, .arr_protected_i, .arr_done_i, .arr_fail_i);
	fscr_host_model host (.clk_i, .cs_n_o(cs_n_i), .sclk_o(sclk_i), .si_o(si_i), .so_i(so_o));
	// Clock, pulse counters and the hang limit.
	always #20 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		n_go += int'(arr_go_o);
		n_pre += int'(block_locks_preset_o);
		cycles++;
		if (cycles == 30000) begin
			n_fail++;
			complete_run();
		end
	end
	// Compares each byte read by the host with the oldest noted expectation.
	always @(host.got) begin
		exp_b = q.pop_front();
		`CHK(exp_b, host.rx_last)
	end
	function automatic logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	task automatic cmd(input logic [31:0] tx, input int nb);
		host.xfer(tx, nb, 0, 0);
	endtask
	task automatic rd(input logic [7:0] op, input logic [7:0] e);
		q.push_back(e);
		host.xfer({24'h0, op}, 8, 1, 0);
	endtask
	// Write enable, one write frame, then a check that the write cycle ran or not.
	task automatic wr(input logic [31:0] tx, input int nb, input logic ok);
		int k;
		cmd({24'h0, OP_WR_ENABLE}, 8);
		cmd(tx, nb);
		`CHK(ok, busy_o)
		for (k = 0; k < 400 && busy_o !== 1'b0; k++) @(negedge clk_i);
	endtask
	task automatic arr_end(input logic fail);
		@(negedge clk_i);
		arr_fail_i = fail;
		arr_done_i = 1'b1;
		@(negedge clk_i);
		arr_done_i = 1'b0;
		repeat (4) @(negedge clk_i);
	endtask
	task automatic power();
		rst_n_i = 1'b0;
		repeat (20) @(negedge clk_i);
		rst_n_i = 1'b1;
		repeat (8) @(negedge clk_i);
	endtask
	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	// Main sequence.
	initial begin
		power();
		rd(OP_RD_STATUS_LO, 8'h00);
		rd(OP_RD_STATUS_HI, 8'h00);
		p0 = n_go;
		cmd({OP_BLOCK4K_CLEAR, 24'h0}, 32);
		`CHK(1'b1, n_go == p0)
		for (int f = 1; f >= 0; f--) begin
			cmd({24'h0, OP_WR_ENABLE}, 8);
			cmd({f[0] ? OP_PAGE_WRITE : OP_BLOCK64K_CLEAR, 24'h0}, 32);
			`CHK(1'b1, n_go == p0 + 2 - f)
			rd(OP_RD_STATUS_LO, 8'h03);
			q.push_back(8'h00);
			host.xfer({24'h0, OP_RD_CONFIG}, 8, 1, 3);
			cmd({24'h0, OP_SUSPEND}, 8);
			`CHK(1'b1, suspend_o)
			rd(OP_RD_STATUS_HI, {5'h10, ~f[0], 2'h0});
			cmd({24'h0, OP_RESUME}, 8);
			`CHK(1'b0, suspend_o)
			arr_end(f[0]);
			rd(OP_RD_STATUS_HI, {5'h0, f[0], 2'h0});
		end
		$display("array and suspend done");
		for (int i = 0; i < 4; i++) begin
			cfg = {i[0], i[1:0], i[1:0], 3'h0};
			wr({16'h0, OP_WR_CONFIG, cfg}, 16, 1'b1);
			rd(OP_RD_CONFIG, cfg);
			`CHK(i[1:0], drive_strength_o)
			`CHK({i == 0 ? 4'h4 : 4'h8, t4[i]}, {dummy_sdr_2io_o, dummy_sdr_4io_o})
			`CHK({i == 0 ? 4'h6 : 4'h8, u4[i]}, {dummy_ddr_1io_o, dummy_ddr_4io_o})
			`CHK({~i[0], i[0]}, {hold_func_en_o, reset_func_en_o})
		end
		wr({16'h0, OP_WR_CONFIG, 8'h02}, 16, 1'b1);
		p0 = n_pre;
		cmd({24'h0, OP_RESET_ARM}, 8);
		cmd({24'h0, OP_RESET_GO}, 8);
		`CHK(2'b11, {addr_4byte_o, n_pre == p0 + 1})
		rd(OP_RD_CONFIG, 8'h03);
		$display("configuration done");
		wp_n_i = 1'b0;
		seed = lfsr(seed);
		vlo = (seed & 8'h78) | 8'h04;
		seed = lfsr(seed);
		vhi = (seed & 8'h7e) | 8'h06;
		wr({8'h0, OP_WR_STATUS, vlo, vhi}, 24, 1'b1);
		rd(OP_RD_STATUS_LO, vlo);
		rd(OP_RD_STATUS_HI, vhi & 8'h7a);
		`CHK(vlo[6:2], block_protect_o)
		`CHK({vhi[6], vhi[5:3], vhi[1]}, {protect_cmp_o, secure_lock_o, quad_io_en_o})
		wr({8'h0, OP_WR_STATUS, 8'h04, 8'h00}, 24, 1'b1);
		rd(OP_RD_STATUS_HI, vhi & 8'h38);
		`CHK(1'b0, quad_io_en_o)
		p0 = n_go;
		wr({24'h0, OP_FULL_CLEAR_A}, 8, 1'b0);
		`CHK(1'b1, n_go == p0)
		rd(OP_RD_STATUS_HI, (vhi & 8'h38) | 8'h04);
		wr({16'h0, OP_WR_STATUS, 8'h84}, 16, 1'b1);
		wr({16'h0, OP_WR_STATUS, 8'h88}, 16, 1'b0);
		rd(OP_RD_STATUS_LO, 8'h86);
		wp_n_i = 1'b1;
		wr({16'h0, OP_WR_STATUS, 8'h8c}, 16, 1'b1);
		rd(OP_RD_STATUS_LO, 8'h8c);
		for (int m = 0; m < 2; m++) begin
			wr({8'h0, OP_WR_STATUS, m[0], 7'h08, 8'h01}, 24, 1'b1);
			wr({16'h0, OP_WR_STATUS, 8'h00}, 16, 1'b0);
			rd(OP_RD_STATUS_LO, {m[0], 7'h0a});
			power();
			rd(OP_RD_STATUS_HI, 8'h00);
		end
		$display("status locks done");
		complete_run();
	end
endmodule
